// *** pkg/spp_defs.vh ***
// Constants for the program message parser: characters, table codes,
// setting limits and queue sizes.
// Assumes a byte stream from the bus front end and a talk-address level.
`ifndef SPP_DEFS_VH
`define SPP_DEFS_VH

// ==========================================================================
// Characters
`define SPP_CH_LF     8'h0A
`define SPP_CH_SPACE  8'h20
`define SPP_CH_STAR   8'h2A
`define SPP_CH_COMMA  8'h2C
`define SPP_CH_ZERO   8'h30
`define SPP_CH_ONE    8'h31
`define SPP_CH_COLON  8'h3A
`define SPP_CH_SEMI   8'h3B
`define SPP_CH_QMARK  8'h3F

// ==========================================================================
// Header table
`define SPP_KW_NUM    6
`define SPP_WORD_MAX  4'h9
`define SPP_ROOT      3'h7
`define SPP_OPT_ROOT  3'h4
`define SPP_K_PATH    2'h0
`define SPP_K_CMD     2'h1
`define SPP_K_NUM     2'h2
`define SPP_K_BOOL    2'h3

// ==========================================================================
// Setting limits and reset values
`define SPP_EN_MIN    8'h00
`define SPP_EN_MAX    8'hFF
`define SPP_EN_DEF    8'h00
`define SPP_RAT_DEF   1'b0

// ==========================================================================
// Output queue
`define SPP_OQ_DEPTH  6'h20
`define SPP_OQ_AW     5

`endif

// *** core/spp_buf2.v ***
// Two-entry buffer between the byte input and the parser.
// Assumes one clock; ready toward the source comes from a flip-flop.
module spp_buf2 (
  // Clock and control
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       ce,
  // Filling side
  input  wire [8:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  // Draining side
  output wire [8:0] out_data,
  output wire       out_valid,
  input  wire       out_ready
);

  reg  [8:0] mem_r [0:1];
  reg        wp_r;
  reg        rp_r;
  reg  [1:0] cnt_r;
  reg        in_ready_r;

  wire       push    = ce & in_valid & in_ready_r;
  wire       pop     = ce & (cnt_r != 2'h0) & out_ready;
  wire [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

  assign in_ready  = in_ready_r;
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_r       <= 1'b0;
      rp_r       <= 1'b0;
      cnt_r      <= 2'h0;
      in_ready_r <= 1'b1;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r      <= cnt_nxt;
      in_ready_r <= (cnt_nxt != 2'h2);
    end
  end

endmodule

// *** core/spp_parser.v ***
// Program message parser: header matching, path pointer, execution and
// response output queue.
// Assumes a byte stream with end-or-identify flag and a talk-address level
// from the bus front end; all inputs synchronous to ref_clk.
`include "spp_defs.vh"

module spp_parser (
  // Clock and control
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       ce,
  // Program message bytes from the host
  input  wire [7:0] rx_data,
  input  wire       rx_eoi,
  input  wire       rx_valid,
  output wire       rx_ready,
  // Response bytes to the host
  input  wire       talk_addr,
  output reg  [7:0] tx_data,
  output reg        tx_eoi,
  output reg        tx_valid,
  input  wire       tx_ready,
  // Status and settings
  output reg        cmd_err,
  output reg        err_seen,
  output reg  [7:0] oper_enable,
  output reg        ratio_en
);

  localparam [2:0] ST_CMD   = 3'h0;
  localparam [2:0] ST_WORD  = 3'h1;
  localparam [2:0] ST_QEND  = 3'h2;
  localparam [2:0] ST_PSP   = 3'h3;
  localparam [2:0] ST_PARAM = 3'h4;
  localparam [2:0] ST_EMIT  = 3'h5;
  localparam [2:0] ST_SKIP  = 3'h6;

  // ========================================================================
  // Header table
  function [71:0] kw_long(input [2:0] i);
  begin
    case (i)
      3'h0:    kw_long = {24'h000000, "STATUS"};
      3'h1:    kw_long = "OPERATION";
      3'h2:    kw_long = {24'h000000, "ENABLE"};
      3'h3:    kw_long = {24'h000000, "PRESET"};
      3'h4:    kw_long = {32'h00000000, "SENSE"};
      default: kw_long = {32'h00000000, "RATIO"};
    endcase
  end
  endfunction

  function [3:0] kw_len(input [2:0] i);
  begin
    case (i)
      3'h1:    kw_len = 4'h9;
      3'h4:    kw_len = 4'h5;
      3'h5:    kw_len = 4'h5;
      default: kw_len = 4'h6;
    endcase
  end
  endfunction

  function [2:0] kw_parent(input [2:0] i);
  begin
    case (i)
      3'h1:    kw_parent = 3'h0;
      3'h2:    kw_parent = 3'h1;
      3'h3:    kw_parent = 3'h0;
      3'h5:    kw_parent = `SPP_OPT_ROOT;
      default: kw_parent = `SPP_ROOT;
    endcase
  end
  endfunction

  function [1:0] kw_kind(input [2:0] i);
  begin
    case (i)
      3'h2:    kw_kind = `SPP_K_NUM;
      3'h3:    kw_kind = `SPP_K_CMD;
      3'h5:    kw_kind = `SPP_K_BOOL;
      default: kw_kind = `SPP_K_PATH;
    endcase
  end
  endfunction

  // Short form length from the spelling
  function [3:0] kw_short(input [71:0] w, input [3:0] n);
    reg [7:0] c4;
  begin
    c4 = 8'h00;
    if (n <= 4'h4)
      kw_short = n;
    else
    begin
      c4 = w[(n - 4) * 8 +: 8];
      if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" ||
          c4 == "U" || c4 == "Y")
        kw_short = 4'h3;
      else
        kw_short = 4'h4;
    end
  end
  endfunction

  function [23:0] dec3(input [7:0] v);
    reg [7:0] h;
    reg [7:0] t;
    reg [7:0] u;
  begin
    h    = v / 8'h64;
    t    = (v / 8'h0A) % 8'h0A;
    u    = v % 8'h0A;
    dec3 = {h + `SPP_CH_ZERO, t + `SPP_CH_ZERO, u + `SPP_CH_ZERO};
  end
  endfunction

  // ========================================================================
  // State
  reg  [2:0]  st_r;
  reg  [2:0]  path_r;
  reg  [71:0] wbuf_r;
  reg  [3:0]  wlen_r;
  reg         common_r;
  reg         q_r;
  reg  [71:0] pbuf_r;
  reg  [3:0]  plen_r;
  reg  [7:0]  pnum_r;
  reg         pdig_r;
  reg  [55:0] resp_r;
  reg  [2:0]  rcnt_r;
  reg         resp_any_r;
  reg  [8:0]  oq_mem [0:31];
  reg  [`SPP_OQ_AW-1:0] oq_wp_r;
  reg  [`SPP_OQ_AW-1:0] oq_rp_r;
  reg  [5:0]  oq_cnt_r;

  // Input bytes pass through the two-entry buffer
  wire [8:0]  b_data;
  wire        b_valid;
  wire        take = (st_r != ST_EMIT);

  spp_buf2 u_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   ({rx_eoi, rx_data}),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (b_data),
    .out_valid (b_valid),
    .out_ready (take)
  );

  wire        pop = ce & b_valid & take;
  wire [7:0]  ch  = b_data[7:0];
  wire [7:0]  cu  = (ch >= "a" && ch <= "z") ? ch - 8'h20 : ch;
  wire        is_alpha = (cu >= "A" && cu <= "Z");
  wire        is_digit = (cu >= "0" && cu <= "9");
  wire        is_term  = b_data[8] | (ch == `SPP_CH_LF);
  wire [7:0]  dval     = cu - `SPP_CH_ZERO;
  wire [11:0] pacc     = {4'h0, pnum_r} * 12'h00A + {8'h00, dval[3:0]};

  // ========================================================================
  // Header match
  wire [`SPP_KW_NUM-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < `SPP_KW_NUM; gi = gi + 1)
    begin : g_kw
      localparam [2:0]  IX = gi;
      localparam [71:0] LG = kw_long(IX);
      localparam [3:0]  LL = kw_len(IX);
      localparam [3:0]  SL = kw_short(LG, LL);
      localparam [2:0]  PA = kw_parent(IX);
      localparam [71:0] SH = LG >> ((LL - SL) * 8);
      wire par_ok = (path_r == PA) ||
                    (path_r == `SPP_ROOT && PA == `SPP_OPT_ROOT);
      assign hit[gi] = !common_r && par_ok &&
                       ((wlen_r == LL && wbuf_r == LG) ||
                        (wlen_r == SL && wbuf_r == SH));
    end
  endgenerate

  reg [2:0] hit_idx;
  integer   k;
  always @*
  begin
    hit_idx = 3'h0;
    for (k = `SPP_KW_NUM - 1; k >= 0; k = k - 1)
      if (hit[k])
        hit_idx = k[2:0];
  end

  wire hit_any = |hit;
  wire com_len = common_r && (wlen_r == 4'h3);
  wire has_p   = (st_r == ST_PARAM);
  wire p_on    = (plen_r == 4'h2 && pbuf_r[15:0] == "ON") ||
                 (plen_r == 4'h1 && pbuf_r[7:0] == `SPP_CH_ONE);
  wire p_off   = (plen_r == 4'h3 && pbuf_r[23:0] == "OFF") ||
                 (plen_r == 4'h1 && pbuf_r[7:0] == `SPP_CH_ZERO);
  wire p_min   = (plen_r == 4'h3 && pbuf_r[23:0] == "MIN") ||
                 (plen_r == 4'h7 && pbuf_r[55:0] == "MINIMUM");
  wire p_max   = (plen_r == 4'h3 && pbuf_r[23:0] == "MAX") ||
                 (plen_r == 4'h7 && pbuf_r[55:0] == "MAXIMUM");
  wire p_def   = (plen_r == 4'h3 && pbuf_r[23:0] == "DEF") ||
                 (plen_r == 4'h7 && pbuf_r[55:0] == "DEFAULT");

  // ========================================================================
  // Command execution decode
  reg        ex_err;
  reg [55:0] ex_resp;
  reg [2:0]  ex_n;
  reg        ex_set_en;
  reg [7:0]  ex_en;
  reg        ex_set_rat;
  reg        ex_rat;
  reg        ex_rst;
  reg        ex_cls;
  reg [7:0]  ex_v;

  always @*
  begin
    ex_err = 1'b0; ex_resp = 56'h0; ex_n = 3'h0; ex_set_en = 1'b0;
    ex_en = oper_enable; ex_set_rat = 1'b0; ex_rat = ratio_en;
    ex_rst = 1'b0; ex_cls = 1'b0; ex_v = oper_enable;
    if (common_r)
    begin
      if (com_len && wbuf_r[23:0] == "RST" && !q_r && !has_p)
        ex_rst = 1'b1;
      else if (com_len && wbuf_r[23:0] == "CLS" && !q_r && !has_p)
        ex_cls = 1'b1;
      else if (com_len && wbuf_r[23:0] == "OPC" && q_r && !has_p)
      begin
        ex_resp = {`SPP_CH_ONE, 48'h0};
        ex_n    = 3'h1;
      end
      else
        ex_err = 1'b1;
    end
    else if (!hit_any)
      ex_err = 1'b1;
    else
      case (kw_kind(hit_idx))
        `SPP_K_CMD:
          if (q_r || has_p)
            ex_err = 1'b1;
          else
            ex_rst = 1'b1;
        `SPP_K_NUM:
          if (q_r)
          begin
            if (p_min)
              ex_v = `SPP_EN_MIN;
            else if (p_max)
              ex_v = `SPP_EN_MAX;
            else if (p_def)
              ex_v = `SPP_EN_DEF;
            else if (has_p)
              ex_err = 1'b1;
            ex_resp = {dec3(ex_v), 32'h0};
            ex_n    = 3'h3;
          end
          else
          begin
            ex_set_en = has_p;
            ex_err    = !has_p;
            if (p_min)
              ex_en = `SPP_EN_MIN;
            else if (p_max)
              ex_en = `SPP_EN_MAX;
            else if (p_def)
              ex_en = `SPP_EN_DEF;
            else if (pdig_r && has_p)
              ex_en = pnum_r;
            else
              ex_err = 1'b1;
          end
        `SPP_K_BOOL:
          if (q_r)
          begin
            ex_err  = has_p;
            ex_resp = {`SPP_CH_ZERO + {7'h00, ratio_en}, 48'h0};
            ex_n    = 3'h1;
          end
          else
          begin
            ex_set_rat = 1'b1;
            ex_rat     = p_on;
            ex_err     = !(p_on || p_off);
          end
        default:
          if (hit_idx == 3'h1 && q_r && !has_p)
          begin
            ex_resp = {dec3(oper_enable), `SPP_CH_COMMA,
                       `SPP_CH_ZERO + {7'h00, ratio_en}, 16'h0};
            ex_n    = 3'h5;
          end
          else
            ex_err = 1'b1;
      endcase
  end

  // ========================================================================
  // Response assembly
  wire at_end = pop & ((cu == `SPP_CH_SEMI) | is_term) &
                ((st_r == ST_WORD) | (st_r == ST_QEND) | (st_r == ST_PARAM));
  wire ex_go  = at_end & !ex_err;
  wire [2:0]  n_x  = ex_go ? ex_n + {2'b00, resp_any_r && ex_n != 3'h0}
                           : 3'h0;
  wire [55:0] r_pre = (resp_any_r && ex_n != 3'h0)
                    ? {`SPP_CH_SEMI, ex_resp[55:8]} : ex_resp;
  wire        any_x = resp_any_r | (n_x != 3'h0);
  wire        lf_x  = is_term & any_x;
  wire [55:0] r_x   = (ex_go ? r_pre : 56'h0) |
                      (lf_x ? ({`SPP_CH_LF, 48'h0} >> {n_x, 3'b000})
                            : 56'h0);
  wire [2:0]  cnt_x = n_x + {2'b00, lf_x};
  wire        bad_t = (at_end & ex_err) | (st_r == ST_PSP);

  wire oq_full = (oq_cnt_r == `SPP_OQ_DEPTH);
  wire oq_push = ce & (st_r == ST_EMIT) & !oq_full;
  wire oq_pop  = ce & talk_addr & (oq_cnt_r != 6'h00) &
                 (!tx_valid | tx_ready);

  // ========================================================================
  // Parser
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= ST_CMD; path_r <= `SPP_ROOT; wbuf_r <= 72'h0;
      wlen_r <= 4'h0; common_r <= 1'b0; q_r <= 1'b0; pbuf_r <= 72'h0;
      plen_r <= 4'h0; pnum_r <= 8'h00; pdig_r <= 1'b1; resp_r <= 56'h0;
      rcnt_r <= 3'h0; resp_any_r <= 1'b0; cmd_err <= 1'b0;
      err_seen <= 1'b0; oper_enable <= `SPP_EN_DEF; ratio_en <= `SPP_RAT_DEF;
    end
    else if (ce)
    begin
      cmd_err <= 1'b0;
      if (ex_go)
      begin
        if (ex_set_en)
          oper_enable <= ex_en;
        if (ex_set_rat)
          ratio_en <= ex_rat;
        if (ex_rst)
        begin
          oper_enable <= `SPP_EN_DEF;
          ratio_en    <= `SPP_RAT_DEF;
        end
        if (ex_cls)
          err_seen <= 1'b0;
      end
      if (st_r == ST_EMIT)
      begin
        if (!oq_full)
        begin
          resp_r <= {resp_r[47:0], 8'h00};
          rcnt_r <= rcnt_r - 3'h1;
          if (rcnt_r == 3'h1)
            st_r <= ST_CMD;
        end
      end
      else if (pop && (is_term || at_end))
      begin
        common_r <= 1'b0; q_r <= 1'b0; wlen_r <= 4'h0; wbuf_r <= 72'h0;
        plen_r <= 4'h0; pbuf_r <= 72'h0; pnum_r <= 8'h00; pdig_r <= 1'b1;
        resp_r <= r_x;
        rcnt_r <= cnt_x;
        if (is_term && bad_t)
        begin
          cmd_err  <= 1'b1;
          err_seen <= 1'b1;
        end
        if (is_term)
        begin
          path_r     <= `SPP_ROOT;
          resp_any_r <= 1'b0;
          st_r       <= (cnt_x != 3'h0) ? ST_EMIT : ST_CMD;
        end
        else if (ex_err)
        begin
          cmd_err  <= 1'b1;
          err_seen <= 1'b1;
          st_r     <= ST_SKIP;
        end
        else
        begin
          resp_any_r <= any_x;
          st_r       <= (cnt_x != 3'h0) ? ST_EMIT : ST_CMD;
        end
      end
      else if (pop)
      begin
        case (st_r)
          ST_CMD:
            if (cu == `SPP_CH_SPACE)
              st_r <= ST_CMD;
            else if (cu == `SPP_CH_COLON)
            begin
              path_r <= `SPP_ROOT;
              st_r   <= ST_WORD;
            end
            else if (cu == `SPP_CH_STAR)
            begin
              common_r <= 1'b1;
              st_r     <= ST_WORD;
            end
            else if (is_alpha)
            begin
              wbuf_r <= {64'h0, cu};
              wlen_r <= 4'h1;
              st_r   <= ST_WORD;
            end
            else
              st_r <= ST_SKIP;
          ST_WORD:
            if ((is_alpha || (is_digit && wlen_r != 4'h0)) &&
                wlen_r != `SPP_WORD_MAX)
            begin
              wbuf_r <= {wbuf_r[63:0], cu};
              wlen_r <= wlen_r + 4'h1;
            end
            else if (cu == `SPP_CH_COLON && hit_any &&
                     kw_kind(hit_idx) == `SPP_K_PATH)
            begin
              path_r <= hit_idx;
              wbuf_r <= 72'h0;
              wlen_r <= 4'h0;
            end
            else if (cu == `SPP_CH_QMARK && wlen_r != 4'h0)
            begin
              q_r  <= 1'b1;
              st_r <= ST_QEND;
            end
            else if (cu == `SPP_CH_SPACE && wlen_r != 4'h0)
              st_r <= ST_PSP;
            else
            begin
              // Unknown word or stray character aborts the message
              st_r     <= ST_SKIP;
              cmd_err  <= 1'b1;
              err_seen <= 1'b1;
            end
          ST_QEND:
            st_r <= (cu == `SPP_CH_SPACE) ? ST_PSP : ST_SKIP;
          ST_PSP:
            if (is_alpha || is_digit)
            begin
              pbuf_r <= {64'h0, cu};
              plen_r <= 4'h1;
              pnum_r <= dval;
              pdig_r <= is_digit;
              st_r   <= ST_PARAM;
            end
            else if (cu != `SPP_CH_SPACE)
              st_r <= ST_SKIP;
          ST_PARAM:
            if ((is_alpha || is_digit) && plen_r != `SPP_WORD_MAX)
            begin
              pbuf_r <= {pbuf_r[63:0], cu};
              plen_r <= plen_r + 4'h1;
              pnum_r <= pacc[7:0];
              pdig_r <= pdig_r & is_digit & (pacc[11:8] == 4'h0);
            end
            else
            begin
              st_r     <= ST_SKIP;
              cmd_err  <= 1'b1;
              err_seen <= 1'b1;
            end
          default:
            st_r <= ST_SKIP;
        endcase
        if ((st_r == ST_CMD && !(cu == `SPP_CH_SPACE ||
             cu == `SPP_CH_COLON || cu == `SPP_CH_STAR || is_alpha)) ||
            (st_r == ST_QEND && cu != `SPP_CH_SPACE) ||
            (st_r == ST_PSP && !(is_alpha || is_digit ||
             cu == `SPP_CH_SPACE)))
        begin
          cmd_err  <= 1'b1;
          err_seen <= 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // Output queue and transmit register
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      oq_wp_r  <= {`SPP_OQ_AW{1'b0}};
      oq_rp_r  <= {`SPP_OQ_AW{1'b0}};
      oq_cnt_r <= 6'h00;
      tx_data  <= 8'h00;
      tx_eoi   <= 1'b0;
      tx_valid <= 1'b0;
    end
    else if (ce)
    begin
      if (oq_push)
      begin
        oq_mem[oq_wp_r] <= {resp_r[55:48] == `SPP_CH_LF, resp_r[55:48]};
        oq_wp_r         <= oq_wp_r + 1'b1;
      end
      if (oq_pop)
      begin
        tx_data  <= oq_mem[oq_rp_r][7:0];
        tx_eoi   <= oq_mem[oq_rp_r][8];
        tx_valid <= 1'b1;
        oq_rp_r  <= oq_rp_r + 1'b1;
      end
      else if (tx_ready)
        tx_valid <= 1'b0;
      oq_cnt_r <= oq_cnt_r + {5'h00, oq_push} - {5'h00, oq_pop};
    end
  end

endmodule

// *** sim/spp_parser_monitor.sv ***
// Checker for the parser's response stream and error flags.
// Assumes binding onto spp_parser; one clock, synchronous reset.
`include "spp_defs.vh"
module spp_parser_mon (
  // Watched ports
  input wire       ref_clk,
  input wire       rst,
  input wire       rx_valid,
  input wire       rx_ready,
  input wire       talk_addr,
  input wire [7:0] tx_data,
  input wire       tx_eoi,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       cmd_err,
  input wire       err_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_last;
    tx_valid && tx_ready && tx_eoi;
  endsequence
  sequence s_semi;
    tx_valid && tx_ready && tx_data == `SPP_CH_SEMI;
  endsequence
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_eoi)) else $error("tx lost");
  a_talk_gate: assert property (!talk_addr && !tx_valid |=>
    !tx_valid) else $error("sent untalked");
  a_eoi_lf: assert property (tx_valid && tx_eoi |->
    tx_data == `SPP_CH_LF) else $error("eoi not on lf");
  a_lf_eoi: assert property (tx_valid && tx_data == `SPP_CH_LF |->
    tx_eoi) else $error("lf without eoi");
  a_last_idle: assert property (s_last |=> !tx_valid)
    else $error("bytes after end");
  a_semi_next: assert property (s_semi |=> !(tx_valid && tx_eoi))
    else $error("end after semicolon");
  a_err_sticky: assert property (cmd_err |=> err_seen)
    else $error("error not held");
  a_err_cause: assert property ($rose(err_seen) |-> cmd_err)
    else $error("error without cause");
  a_rdy_fall: assert property ($fell(rx_ready) |->
    $past(rx_valid) || $past(rx_valid, 2)) else $error("ready fell idle");
endmodule
bind spp_parser spp_parser_mon spp_parser_mon_inst (.ref_clk(ref_clk),
  .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .talk_addr(talk_addr), .tx_data(tx_data), .tx_eoi(tx_eoi),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd_err(cmd_err),
  .err_seen(err_seen));

// *** sim/spp_host.sv ***
// Host model: sends program messages and reads responses.
// Assumes its tasks are called by the bench, one at a time.
`include "spp_defs.vh"
module spp_host (
  // Clock
  input  wire        ref_clk,
  // Program bytes
  output logic [7:0] rx_data,
  output logic       rx_eoi,
  output logic       rx_valid,
  input  wire        rx_ready,
  // Response bytes
  output logic       talk_addr,
  input  wire  [7:0] tx_data,
  input  wire        tx_eoi,
  input  wire        tx_valid,
  output logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  bit slow = 1'b0;
  initial
  begin
    {rx_data, rx_eoi, rx_valid, talk_addr, tx_ready} = 12'h000;
  end
  // =====================================================================
  // Message out, line feed with end-or-identify last
  task send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      rx_data  <= (i == s.len()) ? `SPP_CH_LF : s[i];
      rx_eoi   <= (i == s.len());
      rx_valid <= 1'b1;
      do @(posedge ref_clk); while (!rx_ready);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
  // Talk only after the query was sent; read it all
  task get(output string r, output logic [7:0] last);
    r = "";
    last = 8'h00;
    talk_addr <= 1'b1;
    tx_ready  <= 1'b1;
    repeat (400)
    begin
      @(posedge ref_clk);
      if (tx_valid && tx_ready)
      begin
        last = tx_data;
        if (tx_eoi) break;
        r = {r, string'(tx_data)};
      end
      tx_ready <= slow ? !tx_ready : 1'b1;
    end
    talk_addr <= 1'b0;
    tx_ready  <= 1'b0;
  endtask
endmodule

// *** sim/spp_parser_tb_top.sv ***
// Bench for the program message parser.
// Assumes spp_host as the far side and the bound checker.
`include "spp_defs.vh"
module spp_parser_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  wire  [7:0] rx_data, tx_data, oper_enable;
  wire        rx_eoi, rx_valid, rx_ready, talk_addr, tx_eoi, tx_valid;
  wire        tx_ready, cmd_err, err_seen, ratio_en;
  int         miscompares = 0;
  int         total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  spp_parser spp_parser_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .talk_addr(talk_addr), .tx_data(tx_data),
    .tx_eoi(tx_eoi), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .cmd_err(cmd_err), .err_seen(err_seen), .oper_enable(oper_enable),
    .ratio_en(ratio_en));
  spp_host spp_host_inst (.ref_clk(ref_clk), .rx_data(rx_data),
    .rx_eoi(rx_eoi), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .talk_addr(talk_addr), .tx_data(tx_data), .tx_eoi(tx_eoi),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  // =====================================================================
  // Helpers
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
      begin
        miscompares++;
        $display("Error %s expected %0h seen %0h", n, e, g);
      end
  endtask
  task resp(input string e);
    string      r;
    logic [7:0] last;
    spp_host_inst.get(r, last);
    chk("terminator", `SPP_CH_LF, last);
    total_checks++;
    if (r != e)
      begin
        miscompares++;
        $display("Error response expected %s seen %s", e, r);
      end
  endtask
  task xfer(input string m, input string e);
    spp_host_inst.send(m);
    if (e.len() > 0)
      resp(e);
    else
      repeat (6) @(posedge ref_clk);
  endtask
  task rat(input logic e); chk("ratio", {7'h00, e}, {7'h00, ratio_en}); endtask
  task err(input logic e); chk("err", {7'h00, e}, {7'h00, err_seen}); endtask
  // =====================================================================
  // Scenarios
  task s_bool;
    xfer("SENS:RAT ON", ""); rat(1'b1);
    xfer("rat 0", ""); rat(1'b0);
    xfer("RATIO 1", ""); rat(1'b1);
    xfer("rAt?", "1");
  endtask
  task s_path;
    xfer("stat:oper:enab 5;enab?;:rat?", "005;1");
    xfer("stat:oper:enab? min;enab? max;enab? def", "000;255;000");
    xfer("stat:oper?", "005,1");
  endtask
  task s_short;
    xfer("STATUS:OPER:ENABLE 7", ""); chk("oper", 8'h07, oper_enable);
    xfer("STATu:OPER:ENAB 9", ""); chk("oper", 8'h07, oper_enable);
    err(1'b1);
    xfer("*cls", ""); err(1'b0);
    xfer("RATI 0", ""); rat(1'b1);
    xfer("*CLS;Stat:Oper:Enab?", "007");
  endtask
  task s_order;
    xfer("rat 0;enab 3;rat 1", ""); rat(1'b0);
    xfer("*cls;rat?;foo;rat?", "0"); err(1'b1);
    xfer("stat:oper:enab 4;*cls;enab?", "004"); err(1'b0);
    xfer("*opc?;*rst", "1"); chk("oper", 8'h00, oper_enable);
  endtask
  task s_misc;
    xfer(":stat:oper:enab 2", ""); chk("oper", 8'h02, oper_enable);
    xfer("stat:oper:enab 1;:enab?", ""); err(1'b1);
    xfer("*cls;rat1", ""); err(1'b1);
    xfer("*cls;rat\t1", ""); err(1'b1);
    xfer("*cls;stat:pres", ""); chk("oper", 8'h00, oper_enable);
  endtask
  task s_talk;
    spp_host_inst.send("rat?");
    repeat (20) @(posedge ref_clk);
    chk("tx_valid", 8'h00, {7'h00, tx_valid});
    spp_host_inst.slow = 1'b1;
    resp("0");
    spp_host_inst.slow = 1'b0;
  endtask
  task close_out;
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    s_bool;
    s_path;
    s_short;
    s_order;
    s_misc;
    s_talk;
    close_out;
  end
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    close_out;
  end
endmodule
